//--- rtl/physc_defines.vh
// constants for the transceiver strap and basic control block
`ifndef PHYSC_DEFINES_VH
`define PHYSC_DEFINES_VH

// register offsets
`define PHYSC_ADDR_BASIC 16'h0000
`define PHYSC_ADDR_XCTRL 16'h000D
`define PHYSC_ADDR_XDATA 16'h000E
`define PHYSC_ADDR_STATUS 16'h0010
`define PHYSC_ADDR_MULTI_FUNCTION_INDICATOR 16'h0025
`define PHYSC_ADDR_LEDCFG 16'h0460

// basic_mode_control field positions
`define PHYSC_BC_RESET 15
`define PHYSC_BC_LOOP 14
`define PHYSC_BC_SPEED 13
`define PHYSC_BC_AN_EN 12
`define PHYSC_BC_PWR_DN 11
`define PHYSC_BC_ISOLATE 10
`define PHYSC_BC_RESTART 9
`define PHYSC_BC_DUPLEX 8
`define PHYSC_BC_COL_TEST 7

// status field positions
`define PHYSC_ST_LINK 0
`define PHYSC_ST_LINK_LL 1
`define PHYSC_ST_RXERR_LH 2

// reset values
`define PHYSC_ADDR_DEFAULT 5'h01
`define PHYSC_AN_DEFAULT 1'h1
`define PHYSC_SPEED_DEFAULT 1'h1
`define PHYSC_DUPLEX_DEFAULT 1'h1
`define PHYSC_MULTI_FUNCTION_INDICATOR_RESET 16'h0000
`define PHYSC_LEDCFG_RESET 16'h0000

// mac interface modes
`define PHYSC_IF_MII 2'h0
`define PHYSC_IF_RMII 2'h1
`define PHYSC_IF_RGMII 2'h2
`define PHYSC_IF_RSVD 2'h3

// multi-function indicator routing
`define PHYSC_ROUTE_PIN0 2'h0
`define PHYSC_ROUTE_COL 2'h1

// timing
`define PHYSC_CLK_MHZ 100
`define PHYSC_SOFT_RST_NS 1000
`define PHYSC_SOFT_RST_CYC ((`PHYSC_SOFT_RST_NS * `PHYSC_CLK_MHZ + 999) / 1000)
`define PHYSC_STRAP_SETTLE 2'h2
`define PHYSC_PREAMBLE_LEN 6'h20

`endif

//--- rtl/physc_mdio.v
// serial management frame slave, clause 22 framing
`timescale 1ns/1ps
`include "physc_defines.vh"
module physc_mdio (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [4:0] phy_addr,
  input wire mdc_pin,
  input wire mdio_pin_i,
  output reg mdio_pin_o,
  output reg mdio_pin_oe,
  input wire [15:0] rd_data,
  output reg rd_stb,
  output reg wr_stb,
  output reg [4:0] reg_addr,
  output reg [15:0] wr_data
);
  localparam ST_IDLE = 3'h0;
  localparam ST_HDR = 3'h1;
  localparam ST_TA = 3'h2;
  localparam ST_RD = 3'h3;
  localparam ST_WR = 3'h4;

  reg mdc_s1_q, mdc_s2_q, mdc_s3_q;
  reg dio_s1_q, dio_s2_q;
  reg [2:0] state_q;
  reg [5:0] pre_q;
  reg [4:0] cnt_q;
  reg [16:0] sr_q;
  reg [15:0] tx_q;
  wire rise = mdc_s2_q & ~mdc_s3_q;
  wire bit_in = dio_s2_q;
  wire [12:0] hdr = {sr_q[11:0], bit_in};

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_s1_q <= 1'h0;
      mdc_s2_q <= 1'h0;
      mdc_s3_q <= 1'h0;
      dio_s1_q <= 1'h1;
      dio_s2_q <= 1'h1;
      state_q <= ST_IDLE;
      pre_q <= 6'h00;
      cnt_q <= 5'h00;
      sr_q <= 17'h0_0000;
      tx_q <= 16'h0000;
      mdio_pin_o <= 1'h0;
      mdio_pin_oe <= 1'h0;
      rd_stb <= 1'h0;
      wr_stb <= 1'h0;
      reg_addr <= 5'h00;
      wr_data <= 16'h0000;
    end else if (clk_en) begin
      mdc_s1_q <= mdc_pin;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      dio_s1_q <= mdio_pin_i;
      dio_s2_q <= dio_s1_q;
      rd_stb <= 1'h0;
      wr_stb <= 1'h0;
      if (rise) begin
        sr_q <= {sr_q[15:0], bit_in};
        case (state_q)
          ST_IDLE: begin
            cnt_q <= 5'h00;
            if (bit_in) begin
              if (pre_q != `PHYSC_PREAMBLE_LEN)
                pre_q <= pre_q + 6'h01;
            end else begin
              if (pre_q == `PHYSC_PREAMBLE_LEN)
                state_q <= ST_HDR;
              pre_q <= 6'h00;
            end
          end
          ST_HDR: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h0C) begin
              cnt_q <= 5'h00;
              reg_addr <= hdr[4:0];
              if (!hdr[12] || hdr[9:5] != phy_addr)
                state_q <= ST_IDLE;
              else if (hdr[11:10] == 2'h2) begin
                rd_stb <= 1'h1;
                state_q <= ST_TA;
              end else if (hdr[11:10] == 2'h1)
                state_q <= ST_WR;
              else
                state_q <= ST_IDLE;
            end
          end
          ST_TA: begin
            // second turnaround bit is driven low
            mdio_pin_o <= 1'h0;
            mdio_pin_oe <= 1'h1;
            tx_q <= rd_data;
            state_q <= ST_RD;
          end
          ST_RD: begin
            if (cnt_q == 5'h10) begin
              mdio_pin_oe <= 1'h0;
              state_q <= ST_IDLE;
            end else begin
              mdio_pin_o <= tx_q[15];
              tx_q <= {tx_q[14:0], 1'h0};
              cnt_q <= cnt_q + 5'h01;
            end
          end
          ST_WR: begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h11) begin
              wr_data <= {sr_q[14:0], bit_in};
              wr_stb <= 1'h1;
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // physc_mdio

//--- rtl/physc_top.v
// strap capture, basic mode control and indicator logic
`timescale 1ns/1ps
`include "physc_defines.vh"
// Summary of operation
// - three straps select mac interface and clock
// - multi indicator drives one pin at most
// - led modes come from two writable registers
// - pin sampled low drives active high
// - led polarity set from strap, no software
// - management address latched at reset, 32 choices
// - unpulled address straps give address one
// - address is full five-bit range
// - strap fields reset from sampled pins
// - status bit 0 follows link_up live
// - latched bits hold until read
// - bit 15 resets standard control, self-clears
// - bit 15 reads one during reset
// - bit 14 loops mac transmit to receive
// - bit 13 speed, used without negotiation
// - bit 12 enables negotiation, strap default
// - bit 8 duplex, used without negotiation
// - bit 9 restarts negotiation, self-clears
// - bit 11 powers down, ored with pin
// - bit 10 isolates mac data interface
module physc_top #(
  parameter SOFT_RST_CYC = `PHYSC_SOFT_RST_CYC
) (
  input wire clk,
  input wire sys_rst,
  input wire clk_en,
  input wire mdc_pin,
  input wire mdio_pin_i,
  output wire mdio_pin_o,
  output wire mdio_pin_oe,
  input wire [4:0] strap_phy_addr_pin,
  input wire strap_rgmii_pin,
  input wire strap_rmii_pin,
  input wire ref_clock_fifty_select,
  input wire strap_autoneg_pin,
  input wire strap_speed_pin,
  input wire strap_duplex_pin,
  input wire indicator_pin_zero_i,
  output wire indicator_pin_zero_o,
  output wire indicator_pin_zero_oe,
  input wire indicator_pin_one_i,
  output wire indicator_pin_one_o,
  output wire indicator_pin_one_oe,
  input wire general_pin_two_i,
  output wire general_pin_two_o,
  output wire general_pin_two_oe,
  input wire power_down_input_low,
  input wire [3:0] mac_txd,
  input wire mac_tx_en,
  output reg [3:0] mac_rxd,
  output reg mac_rx_dv,
  output reg mac_rx_oe,
  output reg [3:0] line_txd,
  output reg line_tx_en,
  input wire [3:0] line_rxd,
  input wire line_rx_dv,
  input wire line_col,
  input wire link_up,
  input wire rx_error_event,
  input wire an_started,
  input wire an_speed_100,
  input wire an_full_duplex,
  output reg [1:0] if_mode,
  output reg ref_clk_50,
  output reg [4:0] phy_addr,
  output reg port_speed_100,
  output reg port_full_duplex,
  output reg an_enable,
  output reg an_restart,
  output reg power_down
);
  // strap synchronisers
  wire [13:0] strap_raw = {strap_phy_addr_pin, strap_rgmii_pin,
    strap_rmii_pin, ref_clock_fifty_select, strap_autoneg_pin,
    strap_speed_pin, strap_duplex_pin, general_pin_two_i,
    indicator_pin_one_i, indicator_pin_zero_i};
  reg [13:0] sy1_q, sy2_q;
  reg pd1_q, pd2_q;
  reg [1:0] strap_cnt_q;
  reg strap_done_q;
  reg st_an_q, st_spd_q, st_dup_q;
  reg [2:0] led_pol_q;
  wire strap_cap = !strap_done_q &&
    strap_cnt_q == `PHYSC_STRAP_SETTLE;
  wire pd_pin = ~pd2_q;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sy1_q <= 14'h0000;
      sy2_q <= 14'h0000;
      pd1_q <= 1'h1;
      pd2_q <= 1'h1;
    end else if (clk_en) begin
      sy1_q <= strap_raw;
      sy2_q <= sy1_q;
      pd1_q <= power_down_input_low;
      pd2_q <= pd1_q;
    end
  end

  reg [1:0] mode_d;
  reg clk50_d;
  always @* begin
    mode_d = `PHYSC_IF_RSVD;
    clk50_d = 1'h0;
    if (sy2_q[8]) begin
      if (!sy2_q[6])
        mode_d = `PHYSC_IF_RGMII;
    end else if (sy2_q[7]) begin
      mode_d = `PHYSC_IF_RMII;
      clk50_d = sy2_q[6];
    end else if (!sy2_q[6])
      mode_d = `PHYSC_IF_MII;
  end

  // straps settle through the synchroniser, then latch once
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'h0;
      phy_addr <= `PHYSC_ADDR_DEFAULT;
      if_mode <= `PHYSC_IF_MII;
      ref_clk_50 <= 1'h0;
      st_an_q <= `PHYSC_AN_DEFAULT;
      st_spd_q <= `PHYSC_SPEED_DEFAULT;
      st_dup_q <= `PHYSC_DUPLEX_DEFAULT;
      led_pol_q <= 3'h0;
    end else if (clk_en && !strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cap) begin
        strap_done_q <= 1'h1;
        phy_addr <= sy2_q[13:9];
        if_mode <= mode_d;
        ref_clk_50 <= clk50_d;
        st_an_q <= sy2_q[5];
        st_spd_q <= sy2_q[4];
        st_dup_q <= sy2_q[3];
        led_pol_q <= sy2_q[2:0];
      end
    end
  end

  // management frame slave
  wire mi_rd, mi_wr;
  wire [4:0] mi_ra;
  wire [15:0] mi_wd;
  reg [15:0] rdata_q;
  physc_mdio u_mdio (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .phy_addr(phy_addr),
    .mdc_pin(mdc_pin),
    .mdio_pin_i(mdio_pin_i),
    .mdio_pin_o(mdio_pin_o),
    .mdio_pin_oe(mdio_pin_oe),
    .rd_data(rdata_q),
    .rd_stb(mi_rd),
    .wr_stb(mi_wr),
    .reg_addr(mi_ra),
    .wr_data(mi_wd)
  );

  // extended space reached through the address/data pair
  reg [1:0] xfunc_q;
  reg [15:0] xaddr_q;
  wire xdata = {11'h000, mi_ra} == `PHYSC_ADDR_XDATA;
  wire [15:0] ea = (xdata && xfunc_q != 2'h0) ? xaddr_q :
    {11'h000, mi_ra};
  wire wr_bc = mi_wr && ea == `PHYSC_ADDR_BASIC;
  wire rd_st = mi_rd && ea == `PHYSC_ADDR_STATUS;

  reg [15:0] multi_function_indicator_q, ledcfg_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      xfunc_q <= 2'h0;
      xaddr_q <= 16'h0000;
      multi_function_indicator_q <= `PHYSC_MULTI_FUNCTION_INDICATOR_RESET;
      ledcfg_q <= `PHYSC_LEDCFG_RESET;
    end else if (clk_en && mi_wr) begin
      if (ea == `PHYSC_ADDR_XCTRL)
        xfunc_q <= mi_wd[15:14];
      if (xdata && xfunc_q == 2'h0)
        xaddr_q <= mi_wd;
      if (ea == `PHYSC_ADDR_MULTI_FUNCTION_INDICATOR)
        multi_function_indicator_q <= mi_wd;
      if (ea == `PHYSC_ADDR_LEDCFG)
        ledcfg_q <= mi_wd;
    end
  end

  // basic mode control fields
  reg [15:0] srst_cnt_q;
  reg loop_q, speed_q, an_en_q, pwr_q, iso_q, restart_q;
  reg duplex_q, col_test_q;
  wire srst_act = srst_cnt_q != 16'h0000;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      srst_cnt_q <= 16'h0000;
      loop_q <= 1'h0;
      speed_q <= `PHYSC_SPEED_DEFAULT;
      an_en_q <= `PHYSC_AN_DEFAULT;
      pwr_q <= 1'h0;
      iso_q <= 1'h0;
      restart_q <= 1'h0;
      duplex_q <= `PHYSC_DUPLEX_DEFAULT;
      col_test_q <= 1'h0;
    end else if (clk_en) begin
      if (strap_cap) begin
        an_en_q <= sy2_q[5];
        speed_q <= sy2_q[4];
        duplex_q <= sy2_q[3];
      end else if (srst_act || (wr_bc && mi_wd[`PHYSC_BC_RESET])) begin
        srst_cnt_q <= srst_act ? srst_cnt_q - 16'h0001 :
          SOFT_RST_CYC[15:0];
        loop_q <= 1'h0;
        speed_q <= st_spd_q;
        an_en_q <= st_an_q;
        iso_q <= 1'h0;
        restart_q <= 1'h0;
        duplex_q <= st_dup_q;
        col_test_q <= 1'h0;
        pwr_q <= pd_pin;
      end else if (wr_bc) begin
        loop_q <= mi_wd[`PHYSC_BC_LOOP];
        speed_q <= mi_wd[`PHYSC_BC_SPEED];
        an_en_q <= mi_wd[`PHYSC_BC_AN_EN];
        iso_q <= mi_wd[`PHYSC_BC_ISOLATE];
        duplex_q <= mi_wd[`PHYSC_BC_DUPLEX];
        col_test_q <= mi_wd[`PHYSC_BC_COL_TEST];
        pwr_q <= mi_wd[`PHYSC_BC_PWR_DN] | pd_pin;
        restart_q <= mi_wd[`PHYSC_BC_RESTART] &
          mi_wd[`PHYSC_BC_AN_EN];
      end else begin
        if (an_started || !an_en_q)
          restart_q <= 1'h0;
        if (pd_pin)
          pwr_q <= 1'h1;
      end
    end
  end

  // status: live link, latched-low link, latched-high error
  reg link_ll_q, rxerr_lh_q;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_ll_q <= 1'h0;
      rxerr_lh_q <= 1'h0;
    end else if (clk_en) begin
      link_ll_q <= link_up & (link_ll_q | rd_st);
      rxerr_lh_q <= rx_error_event | (rxerr_lh_q & ~rd_st);
    end
  end

  // read data is captured at the read strobe so a clear-on-read
  // in the same cycle cannot disturb the returned word
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    case (ea)
      `PHYSC_ADDR_BASIC: begin
        rd_mux[`PHYSC_BC_RESET] = srst_act;
        rd_mux[`PHYSC_BC_LOOP] = loop_q;
        rd_mux[`PHYSC_BC_SPEED] = speed_q;
        rd_mux[`PHYSC_BC_AN_EN] = an_en_q;
        rd_mux[`PHYSC_BC_PWR_DN] = pwr_q | pd_pin;
        rd_mux[`PHYSC_BC_ISOLATE] = iso_q;
        rd_mux[`PHYSC_BC_RESTART] = restart_q;
        rd_mux[`PHYSC_BC_DUPLEX] = duplex_q;
        rd_mux[`PHYSC_BC_COL_TEST] = col_test_q;
      end
      `PHYSC_ADDR_XCTRL: rd_mux[15:14] = xfunc_q;
      `PHYSC_ADDR_XDATA: rd_mux = xaddr_q;
      `PHYSC_ADDR_STATUS: begin
        rd_mux[`PHYSC_ST_LINK] = link_up;
        rd_mux[`PHYSC_ST_LINK_LL] = link_ll_q;
        rd_mux[`PHYSC_ST_RXERR_LH] = rxerr_lh_q;
      end
      `PHYSC_ADDR_MULTI_FUNCTION_INDICATOR: rd_mux = multi_function_indicator_q;
      `PHYSC_ADDR_LEDCFG: rd_mux = ledcfg_q;
      default: rd_mux = 16'h0000;
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      rdata_q <= 16'h0000;
    else if (clk_en && mi_rd)
      rdata_q <= rd_mux;
  end

  // indicator sources, selected by three-bit codes
  wire act = mac_tx_en | line_rx_dv;
  wire col_src = col_test_q ? mac_tx_en : line_col;
  wire [7:0] ev = {2'h0, col_src, port_full_duplex, port_speed_100,
    link_up & act, act, link_up};
  wire multi_function_indicator_fn = ev[ledcfg_q[2:0]];
  wire [1:0] route = multi_function_indicator_q[1:0];
  // at most one pin takes the multi indicator, none for routes 2 and 3
  wire [2:0] fn = {
    (route == `PHYSC_ROUTE_COL) ? multi_function_indicator_fn : col_src,
    ev[ledcfg_q[6:4]],
    (route == `PHYSC_ROUTE_PIN0) ? multi_function_indicator_fn : ev[ledcfg_q[10:8]]};
  // collision keeps its own sense unless it carries an indicator
  wire [2:0] inv = {led_pol_q[2] & (route == `PHYSC_ROUTE_COL),
    led_pol_q[1:0]};
  reg [2:0] pin_o_q, pin_oe_q;

  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_led
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pin_o_q[k] <= 1'h0;
          pin_oe_q[k] <= 1'h0;
        end else if (clk_en) begin
          pin_o_q[k] <= fn[k] ^ inv[k];
          // pins stay released until straps are latched
          pin_oe_q[k] <= strap_done_q;
        end
      end
    end
  endgenerate

  assign indicator_pin_zero_o = pin_o_q[0];
  assign indicator_pin_zero_oe = pin_oe_q[0];
  assign indicator_pin_one_o = pin_o_q[1];
  assign indicator_pin_one_oe = pin_oe_q[1];
  assign general_pin_two_o = pin_o_q[2];
  assign general_pin_two_oe = pin_oe_q[2];

  // data path and port controls
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mac_rxd <= 4'h0;
      mac_rx_dv <= 1'h0;
      mac_rx_oe <= 1'h0;
      line_txd <= 4'h0;
      line_tx_en <= 1'h0;
      port_speed_100 <= `PHYSC_SPEED_DEFAULT;
      port_full_duplex <= `PHYSC_DUPLEX_DEFAULT;
      an_enable <= `PHYSC_AN_DEFAULT;
      an_restart <= 1'h0;
      power_down <= 1'h0;
    end else if (clk_en) begin
      mac_rxd <= loop_q ? mac_txd : line_rxd;
      mac_rx_dv <= loop_q ? mac_tx_en : line_rx_dv;
      mac_rx_oe <= ~iso_q;
      line_tx_en <= mac_tx_en & ~(loop_q | iso_q | power_down);
      line_txd <= (loop_q | iso_q | power_down) ? 4'h0 : mac_txd;
      port_speed_100 <= an_en_q ? an_speed_100 : speed_q;
      port_full_duplex <= an_en_q ? an_full_duplex : duplex_q;
      an_enable <= an_en_q;
      an_restart <= restart_q;
      power_down <= pwr_q | pd_pin;
    end
  end
endmodule // physc_top

//--- tb/physc_sta_model.sv
// management station model issuing clause 22 frames
`timescale 1ns/1ps
module physc_sta_model #(
  parameter [4:0] DEV_ADDR = 5'h01
) (
  input wire clk,
  input wire dut_o,
  input wire dut_oe,
  output reg mdc,
  output wire mdio
);
  reg drv_en = 1'h0;
  reg drv_val = 1'h1;
  reg smp;
  // released line rests at the pull-up level
  assign mdio = dut_oe ? dut_o : (drv_en ? drv_val : 1'h1);
  initial mdc = 1'h0;
  // phases of five clocks keep above the four-clock minimum
  task bit_cyc(input b, input en);
    begin
      drv_en = en;
      drv_val = b;
      repeat (5) @(posedge clk);
      #1 mdc = 1'h1;
      smp = mdio;
      repeat (5) @(posedge clk);
      #1 mdc = 1'h0;
    end
  endtask
  task frame(input rd, input [4:0] pa, input [4:0] ra,
    input [15:0] wd, output [15:0] q);
    integer i;
    reg [31:0] hdr;
    begin
      hdr = {2'h1, rd ? 2'h2 : 2'h1, pa, ra, rd ? 2'h3 : 2'h2, wd};
      for (i = 0; i < 32; i = i + 1)
        bit_cyc(1'h1, 1'h1);
      for (i = 31; i >= 0; i = i - 1) begin
        bit_cyc(hdr[i], !rd || i > 17);
        q = {q[14:0], smp};
      end
      bit_cyc(1'h1, 1'h0);
    end
  endtask
  task xacc(input rd, input [15:0] a, input [15:0] d, output [15:0] q);
    begin
      frame(1'h0, DEV_ADDR, 5'h0d, 16'h0000, q);
      frame(1'h0, DEV_ADDR, 5'h0e, a, q);
      frame(1'h0, DEV_ADDR, 5'h0d, 16'h4000, q);
      frame(rd, DEV_ADDR, 5'h0e, d, q);
    end
  endtask
endmodule // physc_sta_model

//--- tb/physc_top_asserts.sv
// concurrent checks on the strap and basic control outputs
`timescale 1ns/1ps
module physc_top_asserts (
  input wire clk,
  input wire sys_rst,
  input wire power_down_input_low,
  input wire [4:0] strap_phy_addr_pin,
  input wire strap_rgmii_pin,
  input wire strap_rmii_pin,
  input wire ref_clock_fifty_select,
  input wire indicator_pin_zero_oe,
  input wire mac_rx_oe,
  input wire line_tx_en,
  input wire an_started,
  input wire an_speed_100,
  input wire [1:0] if_mode,
  input wire ref_clk_50,
  input wire [4:0] phy_addr,
  input wire port_speed_100,
  input wire an_enable,
  input wire an_restart,
  input wire power_down,
  input wire mdio_pin_o,
  input wire mdio_pin_oe
);
  reg [2:0] cnt_q;
  wire [1:0] exp_mode = strap_rgmii_pin ?
    (ref_clock_fifty_select ? 2'h3 : 2'h2) :
    (strap_rmii_pin ? 2'h1 : {2{ref_clock_fifty_select}});
  wire exp_fifty = !strap_rgmii_pin && strap_rmii_pin &&
    ref_clock_fifty_select;
  // counts edges since reset release, saturating past the capture point
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      cnt_q <= 3'h0;
    else if (cnt_q != 3'h7)
      cnt_q <= cnt_q + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_pin_low;
    !power_down_input_low [*4];
  endsequence
  sequence s_neg_start;
    an_restart && an_started;
  endsequence
  a_pwr_pin_sets:
    assert property (s_pin_low |=> power_down)
    else $error("power down did not follow its pin");
  a_line_quiet_pd:
    assert property (power_down && $past(power_down) |-> !line_tx_en)
    else $error("transmit active while powered down");
  a_isolate_quiet:
    assert property (!mac_rx_oe && $past(!mac_rx_oe) |-> !line_tx_en)
    else $error("transmit active while isolated");
  a_addr_capture:
    assert property (cnt_q == 3'h5 |-> phy_addr == strap_phy_addr_pin)
    else $error("address differs from straps");
  a_mode_capture:
    assert property (cnt_q == 3'h5 |->
      if_mode == exp_mode && ref_clk_50 == exp_fifty)
    else $error("interface mode differs from straps");
  a_addr_holds:
    assert property (cnt_q == 3'h7 |-> $stable(phy_addr))
    else $error("address moved after capture");
  a_led_oe_on:
    assert property (cnt_q == 3'h1 |->
      !indicator_pin_zero_oe ##4 indicator_pin_zero_oe)
    else $error("indicator enable timing wrong");
  a_speed_follow:
    assert property (an_enable [*3] ##0
      (cnt_q == 3'h7 && $stable(an_speed_100)) |->
      port_speed_100 == an_speed_100)
    else $error("negotiated speed not applied");
  a_restart_gate:
    assert property ($rose(an_restart) |-> an_enable)
    else $error("restart raised without negotiation");
  a_restart_clear:
    assert property (s_neg_start |=> ##1 !an_restart)
    else $error("restart did not clear");
  a_ta_low:
    assert property ($rose(mdio_pin_oe) |->
      !mdio_pin_o ##1 mdio_pin_oe [*8])
    else $error("turnaround drive wrong");
endmodule // physc_top_asserts
bind physc_top physc_top_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
  .power_down_input_low(power_down_input_low),
  .strap_phy_addr_pin(strap_phy_addr_pin),
  .strap_rgmii_pin(strap_rgmii_pin), .strap_rmii_pin(strap_rmii_pin),
  .ref_clock_fifty_select(ref_clock_fifty_select),
  .indicator_pin_zero_oe(indicator_pin_zero_oe), .mac_rx_oe(mac_rx_oe),
  .line_tx_en(line_tx_en), .an_started(an_started),
  .an_speed_100(an_speed_100), .if_mode(if_mode),
  .ref_clk_50(ref_clk_50), .phy_addr(phy_addr),
  .port_speed_100(port_speed_100), .an_enable(an_enable),
  .an_restart(an_restart), .power_down(power_down),
  .mdio_pin_o(mdio_pin_o), .mdio_pin_oe(mdio_pin_oe));

//--- tb/physc_top_test.sv
// self-checking bench for strap capture and basic control
`timescale 1ns/1ps
`include "physc_defines.vh"
module physc_top_test;
  localparam SOFT_CYC = 2000;
  reg clk = 1'h0;
  reg sys_rst = 1'h1;
  reg [4:0] strap_phy_addr_pin = 5'h01;
  reg strap_rgmii_pin = 1'h0, strap_rmii_pin = 1'h0;
  reg ref_clock_fifty_select = 1'h0, strap_autoneg_pin = 1'h1;
  reg strap_speed_pin = 1'h1, strap_duplex_pin = 1'h1;
  reg indicator_pin_zero_i = 1'h1, indicator_pin_one_i = 1'h0;
  reg power_down_input_low = 1'h1, mac_tx_en = 1'h0, line_rx_dv = 1'h0;
  reg link_up = 1'h0, rx_error_event = 1'h0, an_started = 1'h0;
  reg an_speed_100 = 1'h0, an_full_duplex = 1'h0;
  reg [3:0] mac_txd = 4'h0, line_rxd = 4'h0;
  wire mdc_pin, mdio_pin_i, mdio_pin_o, mdio_pin_oe, mac_rx_dv;
  wire indicator_pin_zero_o, indicator_pin_zero_oe, mac_rx_oe;
  wire indicator_pin_one_o, indicator_pin_one_oe, line_tx_en;
  wire general_pin_two_o, general_pin_two_oe, ref_clk_50, power_down;
  wire port_speed_100, port_full_duplex, an_enable, an_restart;
  wire [3:0] mac_rxd, line_txd;
  wire [1:0] if_mode;
  wire [4:0] phy_addr;
  integer n_mismatch = 0, num_checks = 0;
  reg [15:0] q;
  always #5 clk = ~clk;
  physc_top #(.SOFT_RST_CYC(SOFT_CYC)) u_dut (.clk_en(1'h1),
    .general_pin_two_i(1'h0), .line_col(1'h0), .*);
  physc_sta_model u_sta (.clk(clk), .dut_o(mdio_pin_o),
    .dut_oe(mdio_pin_oe), .mdc(mdc_pin), .mdio(mdio_pin_i));
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task chk(input string what, input [15:0] exp, input [15:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task wr_basic(input [15:0] d);
    u_sta.frame(1'h0, 5'h01, 5'(`PHYSC_ADDR_BASIC), d, q);
  endtask
  task rd_basic;
    u_sta.frame(1'h1, 5'h01, 5'(`PHYSC_ADDR_BASIC), 16'h0000, q);
  endtask
  task do_reset;
    begin
      sys_rst = 1'h1;
      tick(16);
      sys_rst = 1'h0;
      tick(8);
    end
  endtask
  task t_straps;
    integer i;
    reg [1:0] m;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        {strap_rgmii_pin, strap_rmii_pin, ref_clock_fifty_select} = i[2:0];
        strap_phy_addr_pin = i[0] ? 5'h1f : 5'h00;
        strap_autoneg_pin = i[1];
        indicator_pin_zero_i = i[1];
        indicator_pin_one_i = !i[1];
        link_up = 1'h0;
        do_reset;
        m = i[2] ? (i[0] ? `PHYSC_IF_RSVD : `PHYSC_IF_RGMII) :
          (i[1] ? `PHYSC_IF_RMII : (i[0] ? `PHYSC_IF_RSVD : `PHYSC_IF_MII));
        chk("if_mode", 16'(m), 16'(if_mode));
        chk("ref_clk_50", 16'(i == 3), 16'(ref_clk_50));
        chk("phy_addr", i[0] ? 16'h001f : 16'h0000, 16'(phy_addr));
        chk("an_enable", 16'(i[1]), 16'(an_enable));
        chk("led0 off", 16'(i[1]), 16'(indicator_pin_zero_o));
        chk("led1 off", 16'(!i[1]), 16'(indicator_pin_one_o));
        strap_phy_addr_pin = 5'h0a;
        link_up = 1'h1;
        tick(4);
        chk("addr hold", i[0] ? 16'h001f : 16'h0000, 16'(phy_addr));
        chk("led0 on", 16'(!i[1]), 16'(indicator_pin_zero_o));
        chk("led1 on", 16'(i[1]), 16'(indicator_pin_one_o));
      end
    end
  endtask
  task t_regs;
    begin
      {strap_rgmii_pin, strap_rmii_pin, ref_clock_fifty_select} = 3'h0;
      {strap_autoneg_pin, indicator_pin_zero_i} = 2'h3;
      indicator_pin_one_i = 1'h0;
      strap_phy_addr_pin = 5'h01;
      do_reset;
      chk("phy_addr dflt", 16'h0001, 16'(phy_addr));
      rd_basic;
      chk("basic reset", 16'h3100, q);
      wr_basic(16'h317f);
      rd_basic;
      chk("basic rsvd", 16'h3100, q);
      u_sta.frame(1'h1, 5'h02, 5'h00, 16'h0000, q);
      chk("other addr", 16'hffff, q);
    end
  endtask
  task t_led;
    begin
      u_sta.xacc(1'h0, `PHYSC_ADDR_LEDCFG, 16'h0600, q);
      u_sta.xacc(1'h1, `PHYSC_ADDR_LEDCFG, 16'h0000, q);
      chk("led cfg", 16'h0600, q);
      chk("route pin0", 16'h0000, 16'(indicator_pin_zero_o));
      chk("route col", 16'h0000, 16'(general_pin_two_o));
      u_sta.xacc(1'h0, `PHYSC_ADDR_MULTI_FUNCTION_INDICATOR, 16'h0001, q);
      tick(4);
      chk("moved pin0", 16'h0001, 16'(indicator_pin_zero_o));
      chk("moved col", 16'h0001, 16'(general_pin_two_o));
    end
  endtask
  task t_soft;
    begin
      wr_basic(16'h7100);
      rd_basic;
      chk("loop set", 16'h7100, q);
      wr_basic(16'h8000);
      rd_basic;
      chk("rst busy", 16'h0001, 16'(q[15]));
      tick(SOFT_CYC);
      rd_basic;
      chk("rst done", 16'h3100, q);
      u_sta.xacc(1'h1, `PHYSC_ADDR_MULTI_FUNCTION_INDICATOR, 16'h0000, q);
      chk("vendor kept", 16'h0001, q);
    end
  endtask
  task t_loop;
    begin
      {mac_tx_en, mac_txd, line_rxd} = 9'h1a5;
      wr_basic(16'h7100);
      tick(2);
      chk("loop rxd", 16'h000a, 16'(mac_rxd));
      chk("loop dv", 16'h0001, 16'(mac_rx_dv));
      chk("loop tx_en", 16'h0000, 16'(line_tx_en));
      wr_basic(16'h3100);
      tick(2);
      chk("line rxd", 16'h0005, 16'(mac_rxd));
      chk("line txd", 16'h000a, 16'(line_txd));
    end
  endtask
  task t_speed;
    begin
      {an_speed_100, an_full_duplex} = 2'h3;
      wr_basic(16'h0000);
      tick(2);
      chk("forced 10", 16'h0000, 16'(port_speed_100));
      chk("forced half", 16'h0000, 16'(port_full_duplex));
      wr_basic(16'h2300);
      tick(2);
      chk("forced 100", 16'h0001, 16'(port_speed_100));
      chk("forced full", 16'h0001, 16'(port_full_duplex));
      chk("restart off", 16'h0000, 16'(an_restart));
      wr_basic(16'h1200);
      rd_basic;
      chk("restart rd", 16'h1200, q);
      chk("an speed", 16'h0001, 16'(port_speed_100));
      an_started = 1'h1;
      tick(1);
      an_started = 1'h0;
      tick(2);
      chk("restart clr", 16'h0000, 16'(an_restart));
    end
  endtask
  task t_pd_iso;
    begin
      power_down_input_low = 1'h0;
      tick(5);
      chk("pd pin", 16'h0001, 16'(power_down));
      rd_basic;
      chk("pd bit", 16'h0001, 16'(q[11]));
      power_down_input_low = 1'h1;
      wr_basic(16'h1000);
      chk("pd off", 16'h0000, 16'(power_down));
      wr_basic(16'h1400);
      tick(2);
      chk("isolated", 16'h0000, 16'(mac_rx_oe));
      wr_basic(16'h1000);
      tick(2);
      chk("joined", 16'h0001, 16'(mac_rx_oe));
    end
  endtask
  task t_status;
    begin
      rx_error_event = 1'h1;
      tick(1);
      rx_error_event = 1'h0;
      u_sta.xacc(1'h1, `PHYSC_ADDR_STATUS, 16'h0000, q);
      chk("status 1", 16'h0005, q);
      u_sta.xacc(1'h1, `PHYSC_ADDR_STATUS, 16'h0000, q);
      chk("status 2", 16'h0003, q);
      link_up = 1'h0;
      tick(3);
      link_up = 1'h1;
      u_sta.xacc(1'h1, `PHYSC_ADDR_STATUS, 16'h0000, q);
      chk("status 3", 16'h0001, q);
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    $display("[FAIL] run length exp done got hang");
    final_report;
  end
  initial begin
    t_straps;
    t_regs;
    t_led;
    t_soft;
    t_loop;
    t_speed;
    t_pd_iso;
    t_status;
    final_report;
  end
endmodule // physc_top_test
